// File: hw/vlc_pkg.sv
// Shared constants and types for the VPW link configuration registers
package vlc_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_DELAY = 12'h000;
	localparam logic [11:0] OFS_CTRL1 = 12'h004;
	localparam logic [11:0] OFS_CTRL2 = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int DLY_XSEL_BIT = 7;
	localparam int DLY_RECEIVE_POLARITY_BIT = 6;
	localparam int DLY_OFS_LSB = 0;
	localparam int DLY_OFS_W = 4;
	localparam int CTL1_IGNORE_MESSAGE_BIT = 7;
	localparam int CTL1_LINK_CLOCK_SELECT_BIT = 6;
	localparam int CTL1_RATEH_BIT = 5;
	localparam int CTL1_RATEL_BIT = 4;
	localparam int CTL1_IE_BIT = 1;
	localparam int CTL1_WCM_BIT = 0;
	localparam int CTL2_ANALOG_LOOPBACK_BIT = 6;
	localparam int STS_DLY_LOCK_BIT = 0;
	localparam int STS_RATE_LOCK_BIT = 1;
	localparam int STS_STATE_LSB = 2;
	localparam int STS_RX_OK_BIT = 4;
	localparam int STS_TX_OK_BIT = 5;
	localparam int STS_IGNORE_MESSAGE_BIT = 6;

	// ------------------------------------------------------------
	// Reset values and delay mapping
	// ------------------------------------------------------------
	localparam logic [3:0] DELAY_RESET_CODE = 4'h7;
	localparam logic [4:0] DELAY_BASE_US = 5'h09;
	localparam logic [1:0] RATE_RESET = 2'h0;

	// ------------------------------------------------------------
	// Symbol times, in microseconds, and link clock rates
	// ------------------------------------------------------------
	localparam longint EOF_TIME_US = 280;
	localparam longint IFS_TIME_US = 300;
	localparam longint INT_FREQ_HZ = 1000000;
	localparam longint BIN_FREQ_HZ = 1048576;
	localparam int TICK_W = 10;
	// Least times: round up to whole link ticks
	localparam logic [TICK_W-1:0] EOF_TICKS_INT =
		TICK_W'(EOF_TIME_US);
	localparam logic [TICK_W-1:0] IFS_TICKS_INT =
		TICK_W'(IFS_TIME_US);
	localparam logic [TICK_W-1:0] EOF_TICKS_BIN =
		TICK_W'((EOF_TIME_US * BIN_FREQ_HZ + INT_FREQ_HZ - 1)
		/ INT_FREQ_HZ);
	localparam logic [TICK_W-1:0] IFS_TICKS_BIN =
		TICK_W'((IFS_TIME_US * BIN_FREQ_HZ + INT_FREQ_HZ - 1)
		/ INT_FREQ_HZ);

	// ------------------------------------------------------------
	// Loopback recovery states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		VLC_LB_ACTIVE = 2'b00,
		VLC_WAIT_IDLE = 2'b01,
		VLC_READY = 2'b10
	} vlc_link_state_t;

endpackage

// File: hw/vlc_rate_div.sv
// Crystal clock divider producing the link timing clock tick
`timescale 1ns/1ps
module vlc_rate_div #(
	parameter int CNT_W = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic run,
	input wire logic [1:0] rate,
	output logic tick
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] last;
	logic tick_reg;
	logic tick_next;

	// Divide by 1, 2, 4 or 8
	always_comb begin
		last = CNT_W'((1 << rate) - 1);
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (run) begin
			if (cnt_reg >= last) begin
				cnt_next = '0;
				tick_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg & clk_en;
endmodule

// File: hw/vlc_link_regs.sv
// Configuration and control registers of the VPW link controller
//
// Function
// [RQ1] Delay compensation 9 to 24 us in 1 us steps, 16 us after reset.
// [RQ2] Delay register takes only the first write after reset; reads always.
// [RQ3] Transceiver select: 1 on-chip, 0 off-chip; software keeps it 0.
// [RQ4] Receive polarity 1 passes the pin unchanged, 0 inverts it.
// [RQ5] Delay code 0000 is 9 us, each step adds 1 us, 1111 is 24 us.
// [RQ6] Ignore-message disables receiver, masks requests, holds status.
// [RQ7] Start-of-frame or break clears ignore-message; requests resume.
// [RQ8] Clock select: 1 means 1.048576 MHz, 0 means 1 MHz timing.
// [RQ9] Rate codes 00, 01, 10, 11 divide crystal clock by 1, 2, 4, 8.
// [RQ10] Rate bits writable once after reset, then read-only.
// [RQ11] Software picks a rate giving a nominal 1 or 1.048576 MHz tick.
// [RQ12] Interrupt enable gates run-mode requests only, not wake-ups.
// [RQ13] Request stays asserted until all sources are cleared.
// [RQ14] Wait clock mode 1 stops internal clocks in CPU wait mode.
// [RQ15] Software changes transmit control with single-bit set or clear.
// [RQ16] Analog loopback routes drive input to receiver, bus undriven.
// [RQ17] Setting analog loopback resets the protocol state machine.
// [RQ18] After loopback clears, wait for end-of-frame before transmitting.
// [RQ19] After loopback clears, idle EOF time to receive, IFS to transmit.
// [RQ20] Reset loads 16 us delay code and clears both write-once flags.
`timescale 1ns/1ps
module vlc_link_regs #(
	parameter int ADDR_W = 12,
	parameter int TICK_W = vlc_pkg::TICK_W
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic RX_PIN,
	input wire logic TX_BIT,
	input wire logic SOF_DET,
	input wire logic BREAK_DET,
	input wire logic IRQ_PEND,
	input wire logic RUN_MODE,
	input wire logic WAKE_REQ,
	input wire logic CPU_WAIT,
	output logic TX_PIN,
	output logic TX_PIN_EN,
	output logic RX_BIT,
	output logic RX_ENABLE,
	output logic STATUS_HOLD,
	output logic CPU_IRQ,
	output logic LINK_TICK,
	output logic LINK_CLK_BINARY,
	output logic CLOCKS_RUN,
	output logic [4:0] DELAY_US,
	output logic XCVR_ONCHIP,
	output logic SM_RESET,
	output logic RX_ALLOWED,
	output logic TX_ALLOWED
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic xsel_reg, xsel_next;
	logic receive_polarity_reg, receive_polarity_next;
	logic [3:0] dly_code_reg, dly_code_next;
	logic dly_lock_reg, dly_lock_next;
	logic ignore_message_reg, ignore_message_next;
	logic link_clock_select_reg, link_clock_select_next;
	logic [1:0] rate_reg, rate_next;
	logic rate_lock_reg, rate_lock_next;
	logic ie_reg, ie_next;
	logic wcm_reg, wcm_next;
	logic analog_loopback_reg, analog_loopback_next;
	logic [31:0] prdata_reg, prdata_next;

	logic [ADDR_W-1:0] a_delay, a_ctrl1, a_ctrl2, a_status;
	logic acc, wr, mapped;
	logic [7:0] rd_delay, rd_ctrl1, rd_ctrl2, rd_status;

	assign a_delay = ADDR_W'(vlc_pkg::OFS_DELAY);
	assign a_ctrl1 = ADDR_W'(vlc_pkg::OFS_CTRL1);
	assign a_ctrl2 = ADDR_W'(vlc_pkg::OFS_CTRL2);
	assign a_status = ADDR_W'(vlc_pkg::OFS_STATUS);

	// ------------------------------------------------------------
	// APB decode: zero wait states, read data latched in setup
	// ------------------------------------------------------------
	assign acc = PSEL & PENABLE;
	assign wr = acc & PWRITE;
	assign mapped = (PADDR == a_delay) | (PADDR == a_ctrl1) |
		(PADDR == a_ctrl2) | (PADDR == a_status);
	assign PREADY = 1'b1;
	assign PSLVERR = acc & ~mapped;
	assign PRDATA = prdata_reg;

	// ------------------------------------------------------------
	// Link state (loopback recovery)
	// ------------------------------------------------------------
	vlc_pkg::vlc_link_state_t state_reg, state_next;
	logic [TICK_W-1:0] idle_reg, idle_next;
	logic [TICK_W-1:0] eof_ticks, ifs_ticks;
	logic tick;
	logic rx_ok, tx_ok;

	always_comb begin
		rd_delay = '0;
		rd_delay[vlc_pkg::DLY_XSEL_BIT] = xsel_reg;
		rd_delay[vlc_pkg::DLY_RECEIVE_POLARITY_BIT] = receive_polarity_reg;
		rd_delay[vlc_pkg::DLY_OFS_LSB +: vlc_pkg::DLY_OFS_W] = dly_code_reg;
		rd_ctrl1 = '0;
		rd_ctrl1[vlc_pkg::CTL1_IGNORE_MESSAGE_BIT] = ignore_message_reg;
		rd_ctrl1[vlc_pkg::CTL1_LINK_CLOCK_SELECT_BIT] = link_clock_select_reg;
		rd_ctrl1[vlc_pkg::CTL1_RATEH_BIT] = rate_reg[1];
		rd_ctrl1[vlc_pkg::CTL1_RATEL_BIT] = rate_reg[0];
		rd_ctrl1[vlc_pkg::CTL1_IE_BIT] = ie_reg;
		rd_ctrl1[vlc_pkg::CTL1_WCM_BIT] = wcm_reg;
		rd_ctrl2 = '0;
		rd_ctrl2[vlc_pkg::CTL2_ANALOG_LOOPBACK_BIT] = analog_loopback_reg;
		rd_status = '0;
		rd_status[vlc_pkg::STS_DLY_LOCK_BIT] = dly_lock_reg;
		rd_status[vlc_pkg::STS_RATE_LOCK_BIT] = rate_lock_reg;
		rd_status[vlc_pkg::STS_STATE_LSB +: 2] = state_reg;
		rd_status[vlc_pkg::STS_RX_OK_BIT] = rx_ok;
		rd_status[vlc_pkg::STS_TX_OK_BIT] = tx_ok;
		rd_status[vlc_pkg::STS_IGNORE_MESSAGE_BIT] = ignore_message_reg;
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_comb begin
		xsel_next = xsel_reg;
		receive_polarity_next = receive_polarity_reg;
		dly_code_next = dly_code_reg;
		dly_lock_next = dly_lock_reg;
		ignore_message_next = ignore_message_reg;
		link_clock_select_next = link_clock_select_reg;
		rate_next = rate_reg;
		rate_lock_next = rate_lock_reg;
		ie_next = ie_reg;
		wcm_next = wcm_reg;
		analog_loopback_next = analog_loopback_reg;
		prdata_next = prdata_reg;
		if (PSEL & ~PENABLE & ~PWRITE) begin
			prdata_next = '0;
			if (PADDR == a_delay)
				prdata_next[7:0] = rd_delay;
			else if (PADDR == a_ctrl1)
				prdata_next[7:0] = rd_ctrl1;
			else if (PADDR == a_ctrl2)
				prdata_next[7:0] = rd_ctrl2;
			else if (PADDR == a_status)
				prdata_next[7:0] = rd_status;
		end
		if (wr & (PADDR == a_delay) & ~dly_lock_reg) begin // [RQ2]
			xsel_next = PWDATA[vlc_pkg::DLY_XSEL_BIT]; // [RQ3]
			receive_polarity_next = PWDATA[vlc_pkg::DLY_RECEIVE_POLARITY_BIT];
			dly_code_next =
				PWDATA[vlc_pkg::DLY_OFS_LSB +: vlc_pkg::DLY_OFS_W];
			dly_lock_next = 1'b1; // [RQ2]
		end
		if (wr & (PADDR == a_ctrl1)) begin
			ignore_message_next = PWDATA[vlc_pkg::CTL1_IGNORE_MESSAGE_BIT];
			link_clock_select_next = PWDATA[vlc_pkg::CTL1_LINK_CLOCK_SELECT_BIT];
			ie_next = PWDATA[vlc_pkg::CTL1_IE_BIT];
			wcm_next = PWDATA[vlc_pkg::CTL1_WCM_BIT];
			if (~rate_lock_reg) begin // [RQ10]
				rate_next = {PWDATA[vlc_pkg::CTL1_RATEH_BIT],
					PWDATA[vlc_pkg::CTL1_RATEL_BIT]};
				rate_lock_next = 1'b1; // [RQ10]
			end
		end
		if (wr & (PADDR == a_ctrl2))
			analog_loopback_next = PWDATA[vlc_pkg::CTL2_ANALOG_LOOPBACK_BIT];
		// Frame start beats a same-cycle software set, so no frame is lost
		if (SOF_DET | BREAK_DET)
			ignore_message_next = 1'b0; // [RQ7]
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			xsel_reg <= 1'b0;
			receive_polarity_reg <= 1'b0;
			dly_code_reg <= vlc_pkg::DELAY_RESET_CODE; // [RQ20]
			dly_lock_reg <= 1'b0; // [RQ20]
			ignore_message_reg <= 1'b0;
			link_clock_select_reg <= 1'b0;
			rate_reg <= vlc_pkg::RATE_RESET;
			rate_lock_reg <= 1'b0; // [RQ20]
			ie_reg <= 1'b0;
			wcm_reg <= 1'b0;
			analog_loopback_reg <= 1'b0;
			prdata_reg <= '0;
		end else if (CLK_EN) begin
			xsel_reg <= xsel_next;
			receive_polarity_reg <= receive_polarity_next;
			dly_code_reg <= dly_code_next;
			dly_lock_reg <= dly_lock_next;
			ignore_message_reg <= ignore_message_next;
			link_clock_select_reg <= link_clock_select_next;
			rate_reg <= rate_next;
			rate_lock_reg <= rate_lock_next;
			ie_reg <= ie_next;
			wcm_reg <= wcm_next;
			analog_loopback_reg <= analog_loopback_next;
			prdata_reg <= prdata_next;
		end
	end

	// ------------------------------------------------------------
	// Link timing clock
	// ------------------------------------------------------------
	logic clocks_run;

	assign clocks_run = ~(wcm_reg & CPU_WAIT); // [RQ14]

	vlc_rate_div #(
		.CNT_W(3)
	) u_div (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.clk_en(CLK_EN),
		.run(clocks_run),
		.rate(rate_reg), // [RQ9]
		.tick(tick)
	);

	// Symbol timing follows the selected link clock rate
	assign eof_ticks = link_clock_select_reg ? vlc_pkg::EOF_TICKS_BIN :
		vlc_pkg::EOF_TICKS_INT; // [RQ8]
	assign ifs_ticks = link_clock_select_reg ? vlc_pkg::IFS_TICKS_BIN :
		vlc_pkg::IFS_TICKS_INT; // [RQ8]

	// ------------------------------------------------------------
	// Pin conditioning and loopback
	// ------------------------------------------------------------
	logic rx_bit_reg, rx_bit_next;
	logic tx_pin_reg, tx_pin_next;
	logic tx_en_reg, tx_en_next;
	logic sm_rst_reg, sm_rst_next;
	logic irq_reg, irq_next;
	logic [4:0] dly_us_reg, dly_us_next;

	always_comb begin
		// Loopback feeds the final-stage drive input back to the receiver
		if (analog_loopback_reg)
			rx_bit_next = TX_BIT; // [RQ16]
		else
			rx_bit_next = receive_polarity_reg ? RX_PIN : ~RX_PIN; // [RQ4]
		tx_pin_next = analog_loopback_reg ? 1'b0 : TX_BIT; // [RQ16]
		tx_en_next = ~analog_loopback_reg; // [RQ16]
		sm_rst_next = analog_loopback_next & ~analog_loopback_reg; // [RQ17]
		dly_us_next = vlc_pkg::DELAY_BASE_US + {1'b0, dly_code_reg}; // [RQ5]
		// Wake-ups bypass the enable; ignore-message masks everything
		irq_next = ~ignore_message_reg & ((RUN_MODE & ie_reg & IRQ_PEND) |
			(~RUN_MODE & WAKE_REQ)); // [RQ12] [RQ13] [RQ6]
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_bit_reg <= 1'b0;
			tx_pin_reg <= 1'b0;
			tx_en_reg <= 1'b0;
			sm_rst_reg <= 1'b0;
			irq_reg <= 1'b0;
			dly_us_reg <= vlc_pkg::DELAY_BASE_US +
				{1'b0, vlc_pkg::DELAY_RESET_CODE};
		end else if (CLK_EN) begin
			rx_bit_reg <= rx_bit_next;
			tx_pin_reg <= tx_pin_next;
			tx_en_reg <= tx_en_next;
			sm_rst_reg <= sm_rst_next;
			irq_reg <= irq_next;
			dly_us_reg <= dly_us_next; // [RQ1]
		end
	end

	// ------------------------------------------------------------
	// Idle qualification after loopback
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		idle_next = idle_reg;
		unique case (state_reg)
			vlc_pkg::VLC_LB_ACTIVE: begin
				idle_next = '0;
				if (~analog_loopback_reg)
					state_next = vlc_pkg::VLC_WAIT_IDLE;
			end
			vlc_pkg::VLC_WAIT_IDLE: begin
				// Any active bit restarts the idle count
				if (rx_bit_reg)
					idle_next = '0;
				else if (tick & (idle_reg != '1))
					idle_next = idle_reg + TICK_W'(1);
				if ((idle_reg >= ifs_ticks) & (idle_reg >= eof_ticks))
					state_next = vlc_pkg::VLC_READY; // [RQ18] [RQ19]
			end
			vlc_pkg::VLC_READY: begin
				idle_next = '0;
			end
			default: begin
				state_next = vlc_pkg::VLC_WAIT_IDLE;
				idle_next = '0;
			end
		endcase
		if (analog_loopback_reg)
			state_next = vlc_pkg::VLC_LB_ACTIVE; // [RQ17]
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg <= vlc_pkg::VLC_WAIT_IDLE;
			idle_reg <= '0;
		end else if (CLK_EN) begin
			state_reg <= state_next;
			idle_reg <= idle_next;
		end
	end

	assign rx_ok = (state_reg == vlc_pkg::VLC_READY) |
		((state_reg == vlc_pkg::VLC_WAIT_IDLE) &
		(idle_reg >= eof_ticks)); // [RQ19]
	assign tx_ok = (state_reg == vlc_pkg::VLC_READY); // [RQ18]

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign TX_PIN = tx_pin_reg;
	assign TX_PIN_EN = tx_en_reg;
	assign RX_BIT = rx_bit_reg;
	assign RX_ENABLE = ~ignore_message_reg; // [RQ6]
	assign STATUS_HOLD = ignore_message_reg; // [RQ6]
	assign CPU_IRQ = irq_reg;
	assign LINK_TICK = tick;
	assign LINK_CLK_BINARY = link_clock_select_reg;
	assign CLOCKS_RUN = clocks_run;
	assign DELAY_US = dly_us_reg;
	assign XCVR_ONCHIP = xsel_reg;
	assign SM_RESET = sm_rst_reg;
	assign RX_ALLOWED = rx_ok & ~analog_loopback_reg;
	assign TX_ALLOWED = tx_ok & ~analog_loopback_reg;
endmodule

// File: verification/vlc_link_regs_properties.sv
// Port-level assertions for the link configuration register block
`timescale 1ns/1ps
module vlc_link_regs_chk #(
	parameter int ADDR_W = 12
) (
	input logic CORE_CLK,
	input logic RESET_N,
	input logic CLK_EN,
	input logic PSEL,
	input logic PENABLE,
	input logic PWRITE,
	input logic [ADDR_W-1:0] PADDR,
	input logic [31:0] PWDATA,
	input logic SOF_DET,
	input logic BREAK_DET,
	input logic TX_BIT,
	input logic IRQ_PEND,
	input logic RUN_MODE,
	input logic WAKE_REQ,
	input logic CPU_WAIT,
	input logic TX_PIN,
	input logic TX_PIN_EN,
	input logic RX_ENABLE,
	input logic STATUS_HOLD,
	input logic CPU_IRQ,
	input logic CLOCKS_RUN,
	input logic [4:0] DELAY_US,
	input logic SM_RESET,
	input logic RX_ALLOWED,
	input logic TX_ALLOWED
);
	logic dly_wr;

	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESET_N);

	assign dly_wr = PSEL && PENABLE && PWRITE && PADDR == vlc_pkg::OFS_DELAY;

	// ----------------------------------------
	// Loopback entry and recovery
	// ----------------------------------------
	sequence s_lb_set;
		PSEL && PENABLE && PWRITE && CLK_EN && PWDATA[6] &&
			PADDR == vlc_pkg::OFS_CTRL2;
	endsequence
	property p_lb_off;
		s_lb_set |-> ##[1:2] !TX_PIN_EN;
	endproperty
	a_lb_off: assert property (p_lb_off) else $error("bus still driven");
	property p_lb_quiet;
		!TX_PIN_EN |-> !TX_PIN;
	endproperty
	a_lb_quiet: assert property (p_lb_quiet) else $error("tx in loopback");
	property p_tx_follow;
		TX_PIN_EN && $past(CLK_EN) |-> TX_PIN == $past(TX_BIT);
	endproperty
	a_tx_follow: assert property (p_tx_follow) else $error("tx pin lag");
	property p_sm_cause;
		s_lb_set ##0 (TX_PIN_EN && $past(TX_PIN_EN)) |=> SM_RESET;
	endproperty
	a_sm_cause: assert property (p_sm_cause) else $error("no sm reset");
	property p_sm_pulse;
		SM_RESET |=> !SM_RESET;
	endproperty
	a_sm_pulse: assert property (p_sm_pulse) else $error("sm reset long");
	property p_lb_block;
		!TX_PIN_EN && !$past(TX_PIN_EN) |-> !RX_ALLOWED && !TX_ALLOWED;
	endproperty
	a_lb_block: assert property (p_lb_block) else $error("link in loop");
	property p_allow_ord;
		TX_ALLOWED |-> RX_ALLOWED;
	endproperty
	a_allow_ord: assert property (p_allow_ord) else $error("tx before rx");

	// ----------------------------------------
	// Receiver gating, requests and wait-mode clocks
	// ----------------------------------------
	property p_hold_gate;
		PSEL && PENABLE && PWRITE && CLK_EN && PWDATA[7] &&
			PADDR == vlc_pkg::OFS_CTRL1 && !SOF_DET && !BREAK_DET
			|=> STATUS_HOLD && !RX_ENABLE;
	endproperty
	a_hold_gate: assert property (p_hold_gate) else $error("rx gate");
	property p_ignore_message_clr;
		(SOF_DET || BREAK_DET) && CLK_EN |=> RX_ENABLE && !STATUS_HOLD;
	endproperty
	a_ignore_message_clr: assert property (p_ignore_message_clr) else $error("ignore_message stuck");
	property p_hold_mask;
		STATUS_HOLD && CLK_EN |=> !CPU_IRQ;
	endproperty
	a_hold_mask: assert property (p_hold_mask) else $error("irq unmasked");
	property p_wake;
		!RUN_MODE && WAKE_REQ && RX_ENABLE && CLK_EN |=> CPU_IRQ;
	endproperty
	a_wake: assert property (p_wake) else $error("wake lost");
	property p_src_gone;
		!IRQ_PEND && !WAKE_REQ && CLK_EN |=> !CPU_IRQ;
	endproperty
	a_src_gone: assert property (p_src_gone) else $error("stray irq");
	property p_clk_run;
		!CPU_WAIT |-> CLOCKS_RUN;
	endproperty
	a_clk_run: assert property (p_clk_run) else $error("clocks stopped");

	// ----------------------------------------
	// Delay compensation
	// ----------------------------------------
	property p_dly_hold;
		!dly_wr ##1 !dly_wr |=> $stable(DELAY_US);
	endproperty
	a_dly_hold: assert property (p_dly_hold) else $error("delay moved");
	property p_dly_rng;
		DELAY_US >= 5'h09 && DELAY_US <= 5'h18;
	endproperty
	a_dly_rng: assert property (p_dly_rng) else $error("delay range");
endmodule

bind vlc_link_regs vlc_link_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// File: verification/vlc_xcvr_model.sv
// Behavioural external bus transceiver with optional inverted receive
`timescale 1ns/1ps
module vlc_xcvr_model (
	input logic tx_pin,
	input logic tx_pin_en,
	input logic inv,
	input logic ext_act,
	output logic rx_pin
);
	logic bus;
	// Undriven bus rests passive; another node may pull it active
	assign bus = (tx_pin_en & tx_pin) | ext_act;
	// Some transceivers hand the bus level back inverted
	assign rx_pin = bus ^ inv;
endmodule

// File: verification/tb_vpw_link_config_regs.sv
// Self-checking bench for the link configuration registers
`timescale 1ns/1ps
module tb_vpw_link_config_regs;
	logic clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic pready, pslverr, rx_pin, e;
	logic tx_bit = 1'h0, sof = 1'h0, brk = 1'h0, irq_pend = 1'h0;
	logic run_mode = 1'h0, wake = 1'h0, cpu_wait = 1'h0;
	logic inv = 1'h1, ext = 1'h0;
	logic tx_pin, tx_en, rx_bit, rx_en, hold, irq, tick, bin, clk_run;
	logic onchip, sm_rst, rx_ok, tx_ok;
	logic [4:0] dly_us;
	int mismatches = 0, n_checks = 0;

	always #5 clk = ~clk;

	vlc_link_regs uut (
		.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RX_PIN(rx_pin), .TX_BIT(tx_bit),
		.SOF_DET(sof), .BREAK_DET(brk), .IRQ_PEND(irq_pend),
		.RUN_MODE(run_mode), .WAKE_REQ(wake), .CPU_WAIT(cpu_wait),
		.TX_PIN(tx_pin), .TX_PIN_EN(tx_en), .RX_BIT(rx_bit),
		.RX_ENABLE(rx_en), .STATUS_HOLD(hold), .CPU_IRQ(irq),
		.LINK_TICK(tick), .LINK_CLK_BINARY(bin), .CLOCKS_RUN(clk_run),
		.DELAY_US(dly_us), .XCVR_ONCHIP(onchip), .SM_RESET(sm_rst),
		.RX_ALLOWED(rx_ok), .TX_ALLOWED(tx_ok)
	);

	vlc_xcvr_model xcvr (
		.tx_pin(tx_pin), .tx_pin_en(tx_en), .inv(inv), .ext_act(ext),
		.rx_pin(rx_pin)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		chk("pready", pready, 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask

	task automatic do_reset;
		rst_n <= 1'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		chk("dly_us", dly_us, 5'h10);
		apb(1'h0, vlc_pkg::OFS_DELAY, 32'h0000_0000);
		chk("delay", r, 32'h0000_0007);
		apb(1'h0, vlc_pkg::OFS_CTRL1, 32'h0000_0000);
		chk("ctrl1", r, 32'h0000_0000);
		apb(1'h1, vlc_pkg::OFS_STATUS, 32'h0000_00FF);
		apb(1'h0, vlc_pkg::OFS_STATUS, 32'h0000_0000);
		chk("status", r, 32'h0000_0004);
		apb(1'h0, 12'h010, 32'h0000_0000);
		chk("slverr", e, 1'h1);
		chk("unmapped", r, 32'h0000_0000);
	endtask

	task automatic t_delay;
		logic [7:0] v;
		for (int c = 0; c < 16; c++) begin
			v = {c[1], c[0], 2'h0, c[3:0]};
			do_reset;
			inv <= ~v[6];
			apb(1'h1, vlc_pkg::OFS_DELAY, {24'h00_0000, v});
			// Delay output is one register stage behind the code
			@(posedge clk);
			chk("dly_us", dly_us, 5'h09 + c[4:0]);
			chk("onchip", onchip, v[7]);
			ext <= 1'h1;
			repeat (2) @(posedge clk);
			chk("rx_act", rx_bit, 1'h1);
			ext <= 1'h0;
			repeat (2) @(posedge clk);
			chk("rx_idle", rx_bit, 1'h0);
		end
		apb(1'h1, vlc_pkg::OFS_DELAY, 32'h0000_0000);
		apb(1'h0, vlc_pkg::OFS_DELAY, 32'h0000_0000);
		chk("dly_lock", r, 32'h0000_00CF);
		chk("dly_keep", dly_us, 5'h18);
	endtask

	task automatic t_rate;
		int n;
		for (int k = 0; k < 4; k++) begin
			do_reset;
			apb(1'h1, vlc_pkg::OFS_CTRL1,
				{24'h00_0000, 1'h0, k[0], k[1:0], 4'h0});
			chk("binary", bin, k[0]);
			n = 0;
			repeat (64) begin
				@(posedge clk);
				if (tick === 1'h1)
					n++;
			end
			chk("ticks", n, 64 >> k);
			apb(1'h1, vlc_pkg::OFS_CTRL1,
				{24'h00_0000, 2'h0, ~k[1:0], 4'h1});
			apb(1'h0, vlc_pkg::OFS_CTRL1, 32'h0000_0000);
			chk("rate_lock", r[5:4], k[1:0]);
			chk("wcm", r[0], 1'h1);
		end
		cpu_wait <= 1'h1;
		repeat (2) @(posedge clk);
		chk("clk_stop", clk_run, 1'h0);
		cpu_wait <= 1'h0;
		repeat (2) @(posedge clk);
		chk("clk_run", clk_run, 1'h1);
	endtask

	task automatic t_irq;
		apb(1'h1, vlc_pkg::OFS_CTRL1, 32'h0000_0002);
		run_mode <= 1'h1;
		irq_pend <= 1'h1;
		repeat (2) @(posedge clk);
		chk("irq_run", irq, 1'h1);
		apb(1'h1, vlc_pkg::OFS_CTRL1, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk("irq_off", irq, 1'h0);
		run_mode <= 1'h0;
		wake <= 1'h1;
		repeat (2) @(posedge clk);
		chk("wake", irq, 1'h1);
		run_mode <= 1'h1;
		wake <= 1'h0;
		for (int i = 0; i < 2; i++) begin
			apb(1'h1, vlc_pkg::OFS_CTRL1, 32'h0000_0082);
			repeat (2) @(posedge clk);
			chk("hold", hold, 1'h1);
			chk("rx_en", rx_en, 1'h0);
			chk("irq_mask", irq, 1'h0);
			sof <= (i == 0);
			brk <= (i == 1);
			@(posedge clk);
			sof <= 1'h0;
			brk <= 1'h0;
			repeat (2) @(posedge clk);
			chk("hold_clr", hold, 1'h0);
			chk("irq_back", irq, 1'h1);
		end
		irq_pend <= 1'h0;
		repeat (2) @(posedge clk);
		chk("irq_gone", irq, 1'h0);
	endtask

	task automatic t_loop;
		int n, eo, fs;
		// Integer then binary link clock; rate 00 ticks every cycle
		for (int b = 0; b < 2; b++) begin
			eo = (b == 1) ? vlc_pkg::EOF_TICKS_BIN : vlc_pkg::EOF_TICKS_INT;
			fs = (b == 1) ? vlc_pkg::IFS_TICKS_BIN : vlc_pkg::IFS_TICKS_INT;
			do_reset;
			inv <= 1'h1;
			apb(1'h1, vlc_pkg::OFS_CTRL1,
				{24'h00_0000, 1'h0, b[0], 6'h00});
			apb(1'h1, vlc_pkg::OFS_CTRL2, 32'h0000_0040);
			chk("sm_rst", sm_rst, 1'h1);
			tx_bit <= 1'h1;
			repeat (3) @(posedge clk);
			chk("tx_en", tx_en, 1'h0);
			chk("tx_pin", tx_pin, 1'h0);
			chk("lb_rx", rx_bit, 1'h1);
			chk("lb_tx_ok", tx_ok, 1'h0);
			tx_bit <= 1'h0;
			apb(1'h1, vlc_pkg::OFS_CTRL2, 32'h0000_0000);
			repeat (100) @(posedge clk);
			chk("early_tx", tx_ok, 1'h0);
			// Activity on the bus must restart the idle count
			ext <= 1'h1;
			@(posedge clk);
			ext <= 1'h0;
			n = 0;
			while (rx_ok !== 1'h1 && n < 2000) begin
				@(posedge clk);
				n++;
			end
			chk("eof_idle", n >= eo && n <= eo + 4, 1'h1);
			while (tx_ok !== 1'h1 && n < 2000) begin
				@(posedge clk);
				n++;
			end
			chk("ifs_idle", n >= fs && n <= fs + 4, 1'h1);
		end
	endtask

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		#200000;
		mismatches++;
		test_done;
	end

	initial begin
		do_reset;
		t_regs;
		t_delay;
		t_rate;
		t_irq;
		t_loop;
		test_done;
	end
endmodule
